// ### logic/mc2d_reader.sv
`timescale 1ns/1ns
`default_nettype none
module mc2d_reader
    import mc2d_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    // Descriptor handed in by the fetch logic
    input wire logic i_desc_valid,
    output logic o_desc_ready,
    input wire logic [31:0] i_desc_addr,
    input wire logic [31:0] i_buf_addr,
    input wire logic [31:0] i_ctl_word,
    input wire logic [31:0] i_pitch_count_word,
    input wire logic [31:0] i_line_len_word,
    // Status write-back request
    output logic o_sts_valid,
    input wire logic i_sts_ready,
    output logic [31:0] o_sts_addr,
    output logic [31:0] o_channel_status_word,
    output logic o_halted,
    input wire logic i_restart,
    // AXI4 read address channel
    output logic [31:0] o_araddr,
    output logic [7:0] o_arlen,
    output logic [2:0] o_arsize,
    output logic [1:0] o_arburst,
    output logic [3:0] o_arcache,
    output logic [3:0] o_aruser,
    output logic o_arvalid,
    input wire logic i_arready,
    // AXI4 read data channel
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp,
    input wire logic i_rlast,
    input wire logic i_rvalid,
    output logic o_rready,
    // Stream output
    output logic [31:0] o_read_stream_out_tdata,
    output logic [3:0] o_read_stream_out_tkeep,
    output logic o_read_stream_out_tlast,
    output logic [4:0] o_read_stream_out_tdest,
    output logic [4:0] o_read_stream_out_tid,
    output logic [3:0] o_read_stream_out_tuser,
    output logic o_read_stream_out_tvalid,
    input wire logic i_read_stream_out_tready
);
    mc2d_state_e state_q; // Engine state
    logic [31:0] line_base_q; // Start of the current line
    logic [PITCH_W-1:0] pitch_q; // Line start spacing
    logic [LCOUNT_W-1:0] lines_left_q; // Lines still to read
    logic [LLEN_W-1:0] line_len_q; // Bytes per line
    logic end_flag_q; // This buffer closes the packet
    logic [31:0] desc_addr_q; // Where status goes back
    logic [3:0] fault_q; // Done/decode/target/internal
    logic halt_q; // Engine halted on error
    logic [8:0] beats_q; // Beats in the current line
    logic [8:0] beats_left_q; // Beats still expected
    logic [35:0] fifo_in; // Data, keep
    logic [35:0] fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_empty;
    logic last_line;
    logic [3:0] keep_d;
    logic beat_bad; // Error response or burst length mismatch
    logic pop;

    // Beats in one line, rounded up; lines are kept to one burst of 256
    function automatic logic [8:0] line_beats(input logic [LLEN_W-1:0] len);
        logic [LLEN_W:0] b;
        b = ({1'b0, len} + (LLEN_W+1)'(BEAT_BYTES - 1)) >> 2;
        line_beats = (b > 17'd256) ? 9'd256 : b[8:0];
    endfunction

    assign beat_bad = i_rresp[1] || (i_rlast != (beats_left_q == 9'd1));
    assign last_line = (lines_left_q == LCOUNT_W'(1));
    assign o_desc_ready = (state_q == MC2D_IDLE) && !halt_q;
    assign o_rready = (state_q == MC2D_DATA) && fifo_in_ready;
    // Keep marks the tail bytes of the final beat of each line
    assign keep_d = (beats_left_q == 9'd1 && line_len_q[1:0] != 2'h0) ?
        ((4'h1 << line_len_q[1:0]) - 4'h1) : 4'hF;
    assign fifo_in = {keep_d, i_rdata};

    // Buffer absorbs up to FIFO_DEPTH beats of the read burst while the stream stalls
    mc2d_fifo #(
        .WIDTH(36),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_in_valid(i_rvalid && o_rready && !beat_bad && fault_q[2:0] == 3'h0),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_out),
        .o_empty(fifo_empty)
    );
    // Output register takes a new beat when free or being accepted
    assign pop = fifo_out_valid &&
        (!o_read_stream_out_tvalid || i_read_stream_out_tready);

    // Engine sequencing
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= MC2D_IDLE;
            line_base_q <= ZERO_WORD;
            pitch_q <= '0;
            lines_left_q <= '0;
            line_len_q <= '0;
            end_flag_q <= 1'b0;
            desc_addr_q <= ZERO_WORD;
            beats_left_q <= '0;
            beats_q <= '0;
        end else begin
            case (state_q)
                MC2D_IDLE: begin
                    if (i_desc_valid && o_desc_ready) begin
                        line_base_q <= i_buf_addr;
                        pitch_q <= i_pitch_count_word[PITCH_LSB +: PITCH_W];
                        lines_left_q <= i_pitch_count_word[LCOUNT_LSB +: LCOUNT_W];
                        line_len_q <= i_line_len_word[LLEN_LSB +: LLEN_W];
                        end_flag_q <= i_line_len_word[END_FLAG_BIT];
                        desc_addr_q <= i_desc_addr;
                        beats_q <= line_beats(i_line_len_word[LLEN_LSB +: LLEN_W]);
                        state_q <= MC2D_ADDR;
                    end
                end
                MC2D_ADDR: begin
                    if (o_arvalid && i_arready) begin
                        beats_left_q <= beats_q;
                        state_q <= MC2D_DATA;
                    end
                end
                MC2D_DATA: begin
                    // The whole burst is taken even after a fault, so the
                    // memory side is never left stuck in mid-burst
                    if (i_rvalid && o_rready) begin
                        beats_left_q <= beats_left_q - 9'd1;
                        if (i_rlast && (beat_bad || fault_q != 4'h0)) begin
                            state_q <= MC2D_DRAIN;
                        end else if (i_rlast) begin
                            if (last_line) begin
                                state_q <= MC2D_DRAIN;
                            end else begin
                                // Next line starts one pitch on
                                line_base_q <= line_base_q + 32'(pitch_q);
                                lines_left_q <= lines_left_q - 1'b1;
                                state_q <= MC2D_ADDR;
                            end
                        end
                    end
                end
                MC2D_DRAIN: begin
                    // Wait for every beat to leave before status goes out
                    if (fifo_empty && (!o_read_stream_out_tvalid ||
                            i_read_stream_out_tready)) begin
                        state_q <= MC2D_DONE;
                    end
                end
                MC2D_DONE: begin
                    if (o_sts_valid && i_sts_ready) begin
                        state_q <= MC2D_IDLE;
                    end
                end
                default: begin
                    state_q <= MC2D_IDLE;
                end
            endcase
        end
    end

    // Fault flags; cleared only when a new descriptor is taken
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fault_q <= 4'h0;
        end else if (state_q == MC2D_IDLE && i_desc_valid && o_desc_ready) begin
            fault_q <= 4'h0;
        end else if (state_q == MC2D_DATA && i_rvalid && o_rready) begin
            if (i_rresp == RESP_SLVERR) begin
                fault_q[1] <= 1'b1;
            end else if (i_rresp == RESP_DECERR) begin
                fault_q[2] <= 1'b1;
            end else if (i_rlast != (beats_left_q == 9'd1)) begin
                fault_q[0] <= 1'b1;
            end
        end else if (state_q == MC2D_DRAIN && fifo_empty &&
                fault_q[2:0] == 3'h0 && (!o_read_stream_out_tvalid ||
                i_read_stream_out_tready)) begin
            fault_q[3] <= 1'b1;
        end
    end

    // Halt holds after any error until software restarts the engine
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            halt_q <= 1'b0;
        end else if (state_q == MC2D_DONE && o_sts_valid && i_sts_ready &&
                fault_q[2:0] != 3'h0) begin
            halt_q <= 1'b1;
        end else if (i_restart) begin
            halt_q <= 1'b0;
        end
    end

    // Status write-back request, raised once the buffer is fully out
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sts_valid <= 1'b0;
            o_sts_addr <= ZERO_WORD;
            o_channel_status_word <= ZERO_WORD;
            o_halted <= 1'b0;
        end else begin
            o_halted <= halt_q;
            if (state_q == MC2D_DONE && !(o_sts_valid && i_sts_ready)) begin
                o_sts_valid <= 1'b1;
                o_sts_addr <= desc_addr_q + DESC_STS_OFS;
                o_channel_status_word <= {fault_q[3], fault_q[2],
                    fault_q[1], fault_q[0], 28'h0000000};
            end else begin
                o_sts_valid <= 1'b0;
            end
        end
    end

    // Read address channel; one burst per line
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arvalid <= 1'b0;
            o_araddr <= ZERO_WORD;
            o_arlen <= 8'h00;
            o_arcache <= 4'h0;
            o_aruser <= 4'h0;
        end else begin
            if (state_q == MC2D_IDLE && i_desc_valid && o_desc_ready) begin
                o_arcache <= i_ctl_word[CTL_CACHE_LSB +: 4];
                o_aruser <= i_ctl_word[CTL_ARUSER_LSB +: 4];
            end
            if (state_q == MC2D_ADDR && !o_arvalid) begin
                o_arvalid <= 1'b1;
                o_araddr <= line_base_q;
                o_arlen <= 8'(beats_q - 9'd1);
            end else if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
            end
        end
    end
    assign o_arsize = 3'h2;
    assign o_arburst = 2'h1;

    // Stream sideband latched at a begin descriptor, or at any descriptor taken while no beat is on offer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_read_stream_out_tdest <= 5'h00;
            o_read_stream_out_tid <= 5'h00;
            o_read_stream_out_tuser <= 4'h0;
        end else if (state_q == MC2D_IDLE && i_desc_valid && o_desc_ready &&
                (i_line_len_word[BEGIN_FLAG_BIT] ||
                !o_read_stream_out_tvalid)) begin
            o_read_stream_out_tdest <= i_ctl_word[CTL_TDEST_LSB +: 5];
            o_read_stream_out_tid <= i_ctl_word[CTL_TID_LSB +: 5];
            o_read_stream_out_tuser <= i_ctl_word[CTL_TUSER_LSB +: 4];
        end
    end

    // Stream output register; TLAST only on the final beat of an end buffer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_read_stream_out_tvalid <= 1'b0;
            o_read_stream_out_tdata <= ZERO_WORD;
            o_read_stream_out_tkeep <= 4'h0;
            o_read_stream_out_tlast <= 1'b0;
        end else if (pop) begin
            o_read_stream_out_tvalid <= 1'b1;
            o_read_stream_out_tdata <= fifo_out[31:0];
            o_read_stream_out_tkeep <= fifo_out[35:32];
            o_read_stream_out_tlast <= end_flag_q && state_q == MC2D_DRAIN &&
                u_fifo.cnt_q == 5'd1;
        end else if (i_read_stream_out_tready) begin
            o_read_stream_out_tvalid <= 1'b0;
            o_read_stream_out_tlast <= 1'b0;
        end
    end
endmodule // mc2d_reader
`default_nettype wire

// ### common/mc2d_pkg.sv
`default_nettype none
package mc2d_pkg;
    // Descriptor field positions (word-relative)
    localparam int unsigned CTL_TDEST_LSB = 0;
    localparam int unsigned CTL_TID_LSB = 8;
    localparam int unsigned CTL_TUSER_LSB = 16;
    localparam int unsigned CTL_CACHE_LSB = 24;
    localparam int unsigned CTL_ARUSER_LSB = 28;
    localparam int unsigned PITCH_LSB = 0;
    localparam int unsigned LCOUNT_LSB = 19;
    localparam int unsigned LLEN_LSB = 0;
    localparam int unsigned END_FLAG_BIT = 26;
    localparam int unsigned BEGIN_FLAG_BIT = 27;
    localparam int unsigned STS_INTERNAL_BIT = 28;
    localparam int unsigned STS_TARGET_BIT = 29;
    localparam int unsigned STS_DECODE_BIT = 30;
    localparam int unsigned STS_DONE_BIT = 31;
    // Descriptor word offsets, used when writing status back
    localparam logic [31:0] DESC_STS_OFS = 32'h0000001C;
    // Field widths
    localparam int unsigned PITCH_W = 16;
    localparam int unsigned LCOUNT_W = 13;
    localparam int unsigned LLEN_W = 16;
    // Memory data path: 32-bit words, 4 bytes a beat
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BEAT_BYTES = 4;
    localparam int unsigned FIFO_DEPTH = 16;
    // Read response codes
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Reset values
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    // Engine states
    typedef enum logic [2:0] {
        MC2D_IDLE,
        MC2D_ADDR,
        MC2D_DATA,
        MC2D_DRAIN,
        MC2D_DONE
    } mc2d_state_e;
endpackage
`default_nettype wire

// ### logic/mc2d_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// Small flip-flop FIFO with valid/ready on both sides
module mc2d_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic o_empty
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage array
    logic [AW-1:0] wr_q; // Write index
    logic [AW-1:0] rd_q; // Read index
    logic [AW:0] cnt_q; // Occupancy
    logic push;
    logic pop;

    // Full and empty follow occupancy exactly
    assign o_in_ready = (cnt_q < (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_empty = (cnt_q == '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_q];

    // Storage write
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // mc2d_fifo
`default_nettype wire

// ### verif/mc2d_reader_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// Ties reader outputs to the fields of the descriptor it took
module mc2d_reader_asserts (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_desc_valid,
    input wire logic o_desc_ready,
    input wire logic [31:0] i_buf_addr,
    input wire logic [31:0] i_ctl_word,
    input wire logic [31:0] i_pitch_count_word,
    input wire logic [31:0] i_line_len_word,
    input wire logic o_sts_valid,
    input wire logic i_sts_ready,
    input wire logic [31:0] o_channel_status_word,
    input wire logic o_halted,
    input wire logic [31:0] o_araddr,
    input wire logic [7:0] o_arlen,
    input wire logic [2:0] o_arsize,
    input wire logic [1:0] o_arburst,
    input wire logic [3:0] o_arcache,
    input wire logic [3:0] o_aruser,
    input wire logic o_arvalid,
    input wire logic i_arready,
    input wire logic o_read_stream_out_tlast,
    input wire logic [4:0] o_read_stream_out_tdest,
    input wire logic [4:0] o_read_stream_out_tid,
    input wire logic [3:0] o_read_stream_out_tuser,
    input wire logic o_read_stream_out_tvalid,
    input wire logic i_read_stream_out_tready
);
    logic [31:0] ctl_q, pc_q, ll_q, addr_q; // Taken descriptor fields
    logic [21:0] beats_q, tot; // Beats accepted and beats due
    logic [8:0] nb; // Beats per line
    logic take, t_hs, err;
    assign take = i_desc_valid && o_desc_ready;
    assign t_hs = o_read_stream_out_tvalid && i_read_stream_out_tready;
    assign nb = 9'(({1'b0, ll_q[15:0]} + 17'h00003) >> 2);
    assign tot = 22'(nb) * 22'(pc_q[31:19]);
    assign err = |o_channel_status_word[30:28];
    // No reset: these are only consulted once a descriptor is taken
    always_ff @(posedge i_clk) begin
        if (take) begin
            ctl_q <= i_ctl_word;
            pc_q <= i_pitch_count_word;
            ll_q <= i_line_len_word;
            addr_q <= i_buf_addr;
            beats_q <= 22'h000000;
        end else begin
            if (o_arvalid && i_arready) addr_q <= addr_q + 32'(pc_q[15:0]);
            if (t_hs) beats_q <= beats_q + 22'h000001;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_aruser_field: assert property (o_arvalid |-> o_aruser == ctl_q[31:28])
        else $error("aruser differs from the control word");
    chk_cache_field: assert property (o_arvalid |-> o_arcache == ctl_q[27:24])
        else $error("arcache differs from the control word");
    chk_line_start: assert property (o_arvalid |-> o_araddr == addr_q)
        else $error("line start off the pitch grid");
    chk_burst_len: assert property (o_arvalid |-> o_arlen == 8'(nb - 9'h001))
        else $error("burst length differs from line length");
    chk_burst_form: assert property (o_arvalid |->
        o_arsize == 3'h2 && o_arburst == 2'h1)
        else $error("burst is not an incrementing word burst");
    chk_last_place: assert property (t_hs |-> o_read_stream_out_tlast ==
        (ll_q[26] && beats_q == tot - 22'h000001))
        else $error("tlast on the wrong beat");
    chk_side_held: assert property (o_read_stream_out_tvalid |->
        {o_read_stream_out_tuser, o_read_stream_out_tid, o_read_stream_out_tdest}
        == {ctl_q[19:16], ctl_q[12:8], ctl_q[4:0]})
        else $error("stream sideband differs from control word");
    chk_status_late: assert property ($rose(o_sts_valid) && !err |->
        beats_q == tot && o_channel_status_word[31])
        else $error("status before all beats or without done");
    chk_fault_halt: assert property (o_sts_valid && i_sts_ready && err |->
        ##[1:3] o_halted)
        else $error("engine did not halt after a fault");
    cov_pkt_end: cover property (t_hs && o_read_stream_out_tlast);
    cov_fault_sts: cover property (o_sts_valid && i_sts_ready && err);
    cov_restart: cover property ($fell(o_halted));
endmodule // mc2d_reader_asserts
bind mc2d_reader mc2d_reader_asserts mc2d_reader_asserts_i (.*);
`default_nettype wire

// ### verif/mc2d_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// Read slave whose words hold their own address, plus the stream sink
module mc2d_mem_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_slow, // Answer only every other cycle
    input wire logic [1:0] i_bad_resp, // Response code; 01 also cuts bursts
    input wire logic [31:0] i_araddr,
    input wire logic [7:0] i_arlen,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rlast,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_tready
);
    logic busy_q, ph_q, go;
    logic [31:0] addr_q; // Address of the beat on offer
    logic [7:0] left_q; // Beats after this one
    assign go = !i_slow || ph_q;
    assign o_arready = !busy_q && go;
    assign o_tready = go;
    // Idle data is inverted so a stale word never passes for a fresh one
    assign o_rdata = o_rvalid ? addr_q : ~addr_q;
    assign o_rresp = o_rvalid ? i_bad_resp : 2'h0;
    // Code 01 ends each burst of two or more beats one beat early to force an under-run
    assign o_rlast = o_rvalid &&
        (left_q == 8'h00 || (i_bad_resp == 2'h1 && left_q == 8'h01));
    // One burst at a time, a word per beat
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_q <= 1'b0;
            ph_q <= 1'b0;
            o_rvalid <= 1'b0;
            addr_q <= 32'h00000000;
            left_q <= 8'h00;
        end else begin
            ph_q <= !ph_q;
            if (o_arready && i_arvalid) begin
                busy_q <= 1'b1;
                addr_q <= i_araddr;
                left_q <= i_arlen;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                addr_q <= addr_q + 32'h00000004;
                left_q <= left_q - 8'h01;
                busy_q <= !o_rlast;
            end else if (busy_q && go) begin
                o_rvalid <= 1'b1;
            end
        end
    end
endmodule // mc2d_mem_model
`default_nettype wire

// ### verif/tb_mc2d_reader.sv
`timescale 1ns/1ns
`default_nettype none
module tb_mc2d_reader;
    import mc2d_pkg::*;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_desc_valid = 1'b0, i_restart = 1'b0;
    logic i_sts_ready = 1'b0, slow = 1'b0, drop = 1'b0; // drop: faulted run
    logic [31:0] i_desc_addr = 32'h0, i_buf_addr = 32'h0, i_ctl_word = 32'h0;
    logic [31:0] i_pitch_count_word = 32'h0, i_line_len_word = 32'h0;
    logic [1:0] bad = 2'h0, o_arburst, i_rresp; // bad: memory response
    logic o_desc_ready, o_sts_valid, o_halted, o_arvalid, i_arready, i_rlast;
    logic i_rvalid, o_rready, o_read_stream_out_tlast, o_read_stream_out_tvalid;
    logic i_read_stream_out_tready;
    logic [31:0] o_sts_addr, o_channel_status_word, o_araddr, i_rdata;
    logic [31:0] o_read_stream_out_tdata;
    logic [7:0] o_arlen;
    logic [3:0] o_arcache, o_aruser, o_read_stream_out_tkeep;
    logic [3:0] o_read_stream_out_tuser;
    logic [4:0] o_read_stream_out_tdest, o_read_stream_out_tid;
    logic [2:0] o_arsize;
    logic [36:0] qb[$], eb; // Expected beats {last, keep, data}
    logic [95:0] qs[$], es; // Expected status {mask, addr, word}
    logic [31:0] rs = 32'h000071F0; // Generator state
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    mc2d_reader mc2d_reader_i (.*);
    mc2d_mem_model mc2d_mem_model_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_slow(slow), .i_bad_resp(bad), .i_araddr(o_araddr), .i_arlen(o_arlen),
        .i_arvalid(o_arvalid), .o_arready(i_arready), .o_rdata(i_rdata),
        .o_rresp(i_rresp), .o_rlast(i_rlast), .o_rvalid(i_rvalid),
        .i_rready(o_rready), .o_tready(i_read_stream_out_tready));
    initial forever #5 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [31:0] pcw(int lines, int pitch);
        return 32'(lines << 19) | 32'(pitch);
    endfunction
    task automatic cmp(input string nm, input logic [63:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d of %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cycle ceiling; status acceptance stalls one cycle in four
    always @(negedge i_clk) begin
        cyc++;
        i_sts_ready = cyc[1:0] != 2'h0;
        if (cyc == 60000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // Oldest note against each accepted beat outside a faulted run, and each status
    always @(posedge i_clk) begin
        if (i_resetn && o_read_stream_out_tvalid && i_read_stream_out_tready
            && !drop) begin
            eb = qb.size() != 0 ? qb.pop_front() : 37'hX;
            cmp("beat", 64'(eb), 64'({o_read_stream_out_tlast,
                o_read_stream_out_tkeep, o_read_stream_out_tdata}));
        end
        if (i_resetn && o_sts_valid && i_sts_ready) begin
            es = qs.size() != 0 ? qs.pop_front() : 96'hX;
            cmp("status", es[63:0], {o_sts_addr,
                o_channel_status_word & es[95:64]});
        end
    end
    // Note what a descriptor must yield, offer it, wait for its status
    task automatic run(input logic [31:0] b, c, p, l, input logic [1:0] e);
        logic [31:0] d;
        int nb, n;
        d = rnd() & 32'hFFFFFFC0;
        nb = (int'(l[15:0]) + 3) / 4;
        bad = e;
        drop = e != 2'h0;
        for (int y = 0; y < int'(p[31:19]) && !drop; y++) begin
            for (int x = 0; x < nb; x++) begin
                qb.push_back({l[26] && y == p[31:19] - 1 && x == nb - 1,
                    (x == nb - 1 && l[1:0] != 2'h0) ? 4'((1 << l[1:0]) - 1) : 4'hF,
                    b + 32'(y * p[15:0]) + 32'(4 * x)});
            end
        end
        if (drop) qs.push_back({32'hF0000000, d + DESC_STS_OFS,
            e == RESP_SLVERR ? 32'h20000000 :
            (e == RESP_DECERR ? 32'h40000000 : 32'h10000000)});
        else qs.push_back({32'hFFFFFFFF, d + DESC_STS_OFS, 32'h80000000});
        @(negedge i_clk);
        i_desc_valid = 1'b1;
        i_desc_addr = d;
        i_buf_addr = b;
        i_ctl_word = c;
        i_pitch_count_word = p;
        i_line_len_word = l;
        for (n = 0; n < 9000 && o_desc_ready !== 1'b1; n++) @(negedge i_clk);
        @(negedge i_clk);
        i_desc_valid = 1'b0;
        // Released control, pitch and length words turn to junk so late sampling shows up
        i_ctl_word = ~c;
        i_pitch_count_word = ~p;
        i_line_len_word = ~l;
        for (n = 0; n < 9000 && qs.size() != 0; n++) @(negedge i_clk);
        if (qs.size() != 0) begin
            n_mismatch++;
            stop_test();
        end
    endtask
    initial begin
        int len;
        int lens[5];
        logic [31:0] c;
        lens = '{1, 5, 6, 7, 1024};
        repeat (8) @(negedge i_clk);
        i_resetn = 1'b1;
        // Line edges: one byte, partial words, a full 1024-byte burst
        for (int i = 0; i < 5; i++) run(32'h00001000, 32'h03000000,
            pcw(2, ((lens[i] + 11) & -4)), 32'h0C000000 | 32'(lens[i]), 2'h0);
        // Random shapes and sideband; memory and sink sometimes slow
        for (int i = 0; i < 12; i++) begin
            slow = 1'(rnd() % 2);
            c = rnd() & 32'hFF0F1F1F;
            len = 1 + int'(rnd() % 64);
            run(rnd() & 32'h000FFFFC, c, pcw(1 + int'(rnd() % 5),
                ((len + 3) & -4) + 4 * int'(rnd() % 4)),
                32'h0C000000 | 32'(len), 2'h0);
        end
        // One packet over two descriptors with the same sideband
        run(32'h00002000, c, pcw(3, 12), 32'h08000009, 2'h0);
        run(32'h00003000, c, pcw(2, 8), 32'h04000006, 2'h0);
        // Faulting reads: flag, halt, then restart
        // Code 01 has the memory cut each burst a beat short
        for (int i = 0; i < 3; i++) begin
            run(32'h00004000, c, pcw(2, 16), 32'h0C000008,
                i == 0 ? RESP_SLVERR : (i == 1 ? RESP_DECERR : 2'h1));
            repeat (4) @(negedge i_clk);
            cmp("halted", 64'h1, 64'(o_halted));
            cmp("desc_ready", 64'h0, 64'(o_desc_ready));
            i_restart = 1'b1;
            @(negedge i_clk);
            i_restart = 1'b0;
            bad = 2'h0;
            @(negedge i_clk);
            drop = 1'b0;
        end
        run(32'h00005000, 32'h03000000, pcw(4, 20), 32'h0C00000D, 2'h0);
        cmp("beats_left", 64'h0, 64'(qb.size()));
        stop_test();
    end
endmodule // tb_mc2d_reader
`default_nettype wire
